/* File: logic/resp_calib_gpio_regs.sv */
// APB register bank for respiration calibration control and two general pins
`timescale 1ns/10ps
`include "resp_calib_gpio_defines.svh"
module resp_calib_gpio_regs
  import resp_calib_gpio_pkg::*;
#(
  parameter int NPINS = 2
) (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [NPINS-1:0] I_PIN_IN,
  input wire logic I_EXT_RESP_TICK,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic [NPINS-1:0] O_PIN_OUT,
  output logic [NPINS-1:0] O_PIN_OE,
  output logic O_OFFSET_CAL_ENABLE,
  output logic O_LEG_REF_INTERNAL_SELECT,
  output logic O_RESP_TICK
);
  localparam int DIV_LO = `CLK_HZ / `RESP_LO_HZ;
  localparam int DIV_HI = `CLK_HZ / `RESP_HI_HZ;

  // Address compare, shared by the write and the read decode
  function automatic logic is_addr(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction

  // Divider end count; integer division makes both rates slightly fast
  function automatic logic [10:0] div_last(input logic fast);
    return fast ? 11'(DIV_HI - 1) : 11'(DIV_LO - 1);
  endfunction

  reg8_t rcc_q, rcc_d;
  reg8_t rmode_q, rmode_d;
  logic [NPINS-1:0] dir_q, dir_d;
  logic [NPINS-1:0] pin_q, pin_d;
  logic [NPINS-1:0] oe_q, oe_d;
  wire logic [NPINS-1:0] out_q;
  logic [31:0] rdata_q, rdata_d;
  logic ready_q, ready_d;
  logic err_q, err_d;
  logic [10:0] div_q, div_d;
  logic tick_q, tick_d;
  resp_clk_src_t src;
  logic pins_taken;
  logic setup, wr;
  logic hit_rcc, hit_rmode, hit_gpc;
  logic wr_rcc, wr_rmode, wr_gpc;

  assign setup = I_PSEL && !I_PENABLE;
  assign wr = I_PSEL && I_PENABLE && ready_q && I_PWRITE;
  assign hit_rcc = is_addr(I_PADDR, `RCC_ADDR);
  assign hit_rmode = is_addr(I_PADDR, `RMODE_ADDR);
  assign hit_gpc = is_addr(I_PADDR, `GPC_ADDR);
  assign wr_rcc = wr && hit_rcc;
  assign wr_rmode = wr && hit_rmode;
  // Locked while respiration owns the pins
  assign wr_gpc = wr && hit_gpc && !pins_taken;
  assign src = resp_clk_src_t'(rmode_q[`RMODE_CTRL_BIT]);
  assign pins_taken = rmode_q[`RMODE_TAKE_BIT];

  // Calibration and respiration control register
  always_comb begin
    rcc_d = rcc_q;
    if (wr_rcc) begin
      // Reserved bits hold fixed values whatever software writes
      rcc_d = 8'h00;
      rcc_d[`RCC_CAL_BIT] = I_PWDATA[`RCC_CAL_BIT];
      rcc_d[`RCC_FREQ_BIT] = I_PWDATA[`RCC_FREQ_BIT];
      rcc_d[`RCC_REF_BIT] = I_PWDATA[`RCC_REF_BIT];
      rcc_d[`RCC_ONE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rcc_q <= `RCC_RESET;
    end else begin
      rcc_q <= rcc_d;
    end
  end

  // Respiration mode register: clock source and pin takeover
  always_comb begin
    rmode_d = rmode_q;
    if (wr_rmode) begin
      rmode_d = {6'h00, I_PWDATA[`RMODE_TAKE_BIT], I_PWDATA[`RMODE_CTRL_BIT]};
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rmode_q <= `RMODE_RESET;
    end else begin
      rmode_q <= rmode_d;
    end
  end

  // Pin directions, sampled pin levels and output enables
  always_comb begin
    dir_d = dir_q;
    pin_d = I_PIN_IN;
    if (wr_gpc) begin
      dir_d = I_PWDATA[`GPC_DIR_LSB +: NPINS];
    end
    // Enable moves at the same edge as the write that changes it
    oe_d = rmode_d[`RMODE_TAKE_BIT] ? '0 : ~dir_d;
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      dir_q <= '1;
      pin_q <= '0;
      oe_q <= '0;
    end else begin
      dir_q <= dir_d;
      pin_q <= pin_d;
      oe_q <= oe_d;
    end
  end

  // Driven level per pin; a data write uses the direction held before it
  for (genvar g = 0; g < NPINS; g++) begin : g_pin
    logic level_q, level_d;

    always_comb begin
      level_d = level_q;
      // Input pins ignore data writes; readback stays the pin level
      if (wr_gpc && !dir_q[g]) begin
        level_d = I_PWDATA[`GPC_DATA_LSB + g];
      end
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
        level_q <= 1'b0;
      end else begin
        level_q <= level_d;
      end
    end

    assign out_q[g] = level_q;
  end

  // APB answer: one wait-free access phase after every setup
  always_comb begin
    rdata_d = rdata_q;
    ready_d = setup;
    err_d = 1'b0;
    if (setup) begin
      rdata_d = 32'h0000_0000;
      if (hit_rcc) begin
        rdata_d[7:0] = rcc_q;
      end else if (hit_rmode) begin
        rdata_d[7:0] = rmode_q;
      end else if (hit_gpc) begin
        rdata_d[`GPC_DIR_LSB +: NPINS] = dir_q;
        rdata_d[`GPC_DATA_LSB +: NPINS] = pin_q;
      end else begin
        // Unmapped addresses answer with an error and zero data
        err_d = 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rdata_q <= 32'h0000_0000;
      ready_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      err_q <= err_d;
    end
  end

  // Respiration strobe: divider on the device clock or the external tick
  always_comb begin
    div_d = div_q + 11'h001;
    tick_d = 1'b0;
    if (src == RESP_CLK_EXTERNAL) begin
      div_d = 11'h000;
      tick_d = I_EXT_RESP_TICK;
    end else if (div_q >= div_last(rcc_q[`RCC_FREQ_BIT])) begin
      div_d = 11'h000;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      div_q <= 11'h000;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  assign O_PRDATA = rdata_q;
  assign O_PREADY = ready_q;
  assign O_PSLVERR = err_q;
  assign O_PIN_OUT = out_q;
  assign O_PIN_OE = oe_q;
  assign O_OFFSET_CAL_ENABLE = rcc_q[`RCC_CAL_BIT];
  assign O_LEG_REF_INTERNAL_SELECT = rcc_q[`RCC_REF_BIT];
  assign O_RESP_TICK = tick_q;
endmodule // resp_calib_gpio_regs

/* File: pkg/resp_calib_gpio_defines.svh */
// Register offsets, field positions, reset values and rates for the calibration/pin block
`ifndef RESP_CALIB_GPIO_DEFINES_SVH
`define RESP_CALIB_GPIO_DEFINES_SVH

// Register indices as printed; byte address is four times the index
`define RCC_INDEX 8'h0A
`define GPC_INDEX 8'h0B
`define RCC_ADDR 12'h028
`define GPC_ADDR 12'h02C

// Calibration/respiration register fields
`define RCC_CAL_BIT 7
`define RCC_FREQ_BIT 2
`define RCC_REF_BIT 1
`define RCC_ONE_BIT 0
`define RCC_RESET 8'h03

// Respiration mode register (own choice) fields
`define RMODE_ADDR 12'h030
`define RMODE_CTRL_BIT 0
`define RMODE_TAKE_BIT 1
`define RMODE_RESET 8'h00

// Pin register fields
`define GPC_DIR_LSB 2
`define GPC_DATA_LSB 0
`define GPC_RESET 8'h0C

// Clock rates used to derive the respiration strobe
`define CLK_HZ 50000000
`define RESP_LO_HZ 32000
`define RESP_HI_HZ 64000

`endif

/* File: pkg/resp_calib_gpio_pkg.sv */
// Types shared by the calibration/pin register block
package resp_calib_gpio_pkg;
  typedef enum logic {
    RESP_CLK_INTERNAL,
    RESP_CLK_EXTERNAL
  } resp_clk_src_t;
  typedef logic [7:0] reg8_t;
endpackage

/* File: tb/resp_calib_gpio_regs_assertions.sv */
// Port-level checks for the calibration and pin register bank
`timescale 1ns/10ps
`include "resp_calib_gpio_defines.svh"
module rcg_checker (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic [1:0] O_PIN_OE,
  input wire logic O_OFFSET_CAL_ENABLE,
  input wire logic O_LEG_REF_INTERNAL_SELECT
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  wire logic set = I_PSEL && !I_PENABLE;
  wire logic wr = I_PSEL && I_PENABLE && I_PWRITE && O_PREADY;
  wire logic rcc = wr && I_PADDR == `RCC_ADDR;
  wire logic map = I_PADDR inside {`RCC_ADDR, `GPC_ADDR, `RMODE_ADDR};
  rdy_after_setup_a: assert property (set |=> O_PREADY) else $error("no ready");
  rdy_in_access_a: assert property (O_PREADY |-> I_PSEL && I_PENABLE) else $error("stray");
  bad_addr_a: assert property (set && !map |=> O_PSLVERR) else $error("no error");
  good_addr_a: assert property (set && map |=> !O_PSLVERR) else $error("false error");
  cal_write_a:
    assert property (rcc |=> O_OFFSET_CAL_ENABLE == $past(I_PWDATA[7])) else $error("cal");
  ref_write_a:
    assert property (rcc |=> O_LEG_REF_INTERNAL_SELECT == $past(I_PWDATA[1])) else $error("ref");
  cal_hold_a: assert property (!rcc |=> $stable(O_OFFSET_CAL_ENABLE)) else $error("cal");
  oe_hold_a: assert property (!wr |=> $stable(O_PIN_OE)) else $error("oe moved");
  cover property (rcc);
  cover property (set && !map);
  cover property ($rose(O_PIN_OE[0]));
endmodule // rcg_checker
bind resp_calib_gpio_regs rcg_checker i_chk (.I_CLK, .I_RST_N, .I_PSEL, .I_PENABLE,
  .I_PWRITE, .I_PADDR, .I_PWDATA, .O_PREADY, .O_PSLVERR, .O_PIN_OE,
  .O_OFFSET_CAL_ENABLE, .O_LEG_REF_INTERNAL_SELECT);

/* File: tb/testbench.sv */
// Self-checking bench for the calibration and pin register bank
`timescale 1ns/10ps
`include "resp_calib_gpio_defines.svh"
module testbench;
  logic I_CLK = 0, I_RST_N = 0, I_PSEL = 0, I_PENABLE = 0, I_PWRITE = 0, I_EXT_RESP_TICK = 0;
  logic [11:0] I_PADDR = 12'h000;
  logic [31:0] I_PWDATA = 32'h0, O_PRDATA, rd;
  logic [1:0] I_PIN_IN = 2'h2, O_PIN_OUT, O_PIN_OE;
  logic O_PREADY, O_PSLVERR, O_OFFSET_CAL_ENABLE, O_LEG_REF_INTERNAL_SELECT, O_RESP_TICK, er;
  int errors = 0, checked = 0, cyc = 0;
  resp_calib_gpio_regs i_dut (.I_CLK, .I_RST_N, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR,
    .I_PWDATA, .I_PIN_IN, .I_EXT_RESP_TICK, .O_PRDATA, .O_PREADY, .O_PSLVERR, .O_PIN_OUT,
    .O_PIN_OE, .O_OFFSET_CAL_ENABLE, .O_LEG_REF_INTERNAL_SELECT, .O_RESP_TICK);
  initial begin
    forever #10 I_CLK = ~I_CLK;
  end
  task automatic tally_and_finish;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge I_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish;
    end
  end
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // Request held until pready is seen at an edge
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge I_CLK);
    {I_PSEL, I_PENABLE, I_PWRITE, I_PADDR, I_PWDATA} <= {1'b1, 1'b0, w, a, d};
    @(posedge I_CLK);
    I_PENABLE <= 1;
    do @(posedge I_CLK); while (O_PREADY !== 1'b1);
    rd = O_PRDATA;
    er = O_PSLVERR;
    {I_PSEL, I_PENABLE} <= 2'h0;
    // One more edge so that written values stand on the outputs
    @(posedge I_CLK);
  endtask
  task automatic t_rcc;
    apb(0, `RCC_ADDR, 0); chk("rcc reset", 32'h03, rd);
    apb(1, `RCC_ADDR, 32'h87); apb(0, `RCC_ADDR, 0); chk("rcc ff", 32'h87, rd);
    chk("cal", 1, O_OFFSET_CAL_ENABLE);
    apb(1, `RCC_ADDR, 32'h01); chk("ref ext", 0, O_LEG_REF_INTERNAL_SELECT);
    apb(0, 12'h040, 0); chk("unmapped", 32'h1, {rd[30:0], er});
    $display("rcc test done");
  endtask
  task automatic t_pins;
    apb(1, `GPC_ADDR, 32'h0F); apb(0, `GPC_ADDR, 0); chk("pin in", 32'h0E, rd);
    apb(1, `GPC_ADDR, 32'h00); chk("oe", 32'h0C, {O_PIN_OE, O_PIN_OUT});
    apb(1, `GPC_ADDR, 32'h02); I_PIN_IN <= 2'h1; chk("out", 32'h0E, {O_PIN_OE, O_PIN_OUT});
    apb(0, `GPC_ADDR, 0); chk("pin rd", 32'h01, rd);
    apb(1, `RMODE_ADDR, 32'h02); chk("taken", 32'h0, {30'h0, O_PIN_OE});
    apb(1, `GPC_ADDR, 32'h0C); apb(0, `GPC_ADDR, 0); chk("locked", 32'h01, rd);
    $display("pin test done");
  endtask
  task automatic per(int e);
    int n;
    repeat (2) do @(posedge I_CLK); while (O_RESP_TICK !== 1'b1);
    n = 0;
    do begin @(posedge I_CLK); n++; end while (O_RESP_TICK !== 1'b1);
    chk("tick period", e, n);
  endtask
  task automatic t_tick;
    per(`CLK_HZ / `RESP_LO_HZ);
    apb(1, `RCC_ADDR, 32'h07); per(`CLK_HZ / `RESP_HI_HZ);
    apb(1, `RMODE_ADDR, 32'h01); I_EXT_RESP_TICK <= 1;
    @(posedge I_CLK); I_EXT_RESP_TICK <= 0; #1 chk("ext tick", 1, O_RESP_TICK);
    $display("tick test done");
  endtask
  initial begin
    repeat (10) @(posedge I_CLK);
    I_RST_N <= 1;
    t_rcc;
    t_pins;
    t_tick;
    tally_and_finish;
  end
endmodule // testbench
